/* design/slpc_pkg.sv */
// shared constants of the sleep-mode controller
package slpc_pkg;

  // sleep mode select codes
  localparam logic [2:0] MODE_IDLE        = 3'h0;
  localparam logic [2:0] MODE_ADC_NR      = 3'h1;
  localparam logic [2:0] MODE_PDOWN       = 3'h2;
  localparam logic [2:0] MODE_PSAVE       = 3'h3;
  localparam logic [2:0] MODE_RSVD_A      = 3'h4;
  localparam logic [2:0] MODE_RSVD_B      = 3'h5;
  localparam logic [2:0] MODE_STANDBY     = 3'h6;
  localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

  // mcu_control_reg field positions and reset values
  localparam int unsigned MCU_CTRL_W           = 8;
  localparam int unsigned BROWNOUT_OFF_BIT     = 6;
  localparam int unsigned BROWNOUT_UNLOCK_BIT  = 5;
  localparam logic        BROWNOUT_OFF_RESET   = 1'b0;

  // timing
  localparam int unsigned CLK_PERIOD_NS        = 8;
  localparam int unsigned BOD_WAKE_US          = 60;
  localparam int unsigned CNT_W                = 16;
  localparam logic [15:0] HALT_CYC             = 16'h0004;
  localparam logic [15:0] STANDBY_WAKE_CYC     = 16'h0006;
  localparam logic [2:0]  UNLOCK_CYC           = 3'h4;

  // start-up delay per clock_select_cfg setting
  localparam logic [15:0] STARTUP_CYC_0        = 16'h0010;
  localparam logic [15:0] STARTUP_CYC_1        = 16'h0100;
  localparam logic [15:0] STARTUP_CYC_2        = 16'h0800;
  localparam logic [15:0] STARTUP_CYC_3        = 16'h1000;

endpackage : slpc_pkg

/* design/slpc_brownout_sleep_off_if.sv */
// carrier between the sleep controller and its brown-out unlock unit
`timescale 1ns/1ps
interface slpc_brownout_sleep_off_if;
  logic       wr;
  logic [7:0] wdata;
  logic       sleep_off;
  logic       unlock_open;

  modport ctl  (output wr, output wdata, input sleep_off, input unlock_open);
  modport unit (input wr, input wdata, output sleep_off, output unlock_open);
endinterface : slpc_brownout_sleep_off_if

/* design/slpc_brownout_sleep_off_unlock.sv */
// timed unlock for the brownout_sleep_off bit
`timescale 1ns/1ps
module slpc_brownout_sleep_off_unlock (
  input wire logic  i_ref_clk,
  input wire logic  i_resetn,
  slpc_brownout_sleep_off_if.unit bus
);

  logic [2:0] win_cnt;
  logic [2:0] next_win_cnt;
  logic       wr_off;
  logic       wr_unlock;
  logic       open_wr;
  logic       commit_wr;

  assign wr_off    = bus.wdata[slpc_pkg::BROWNOUT_OFF_BIT];
  assign wr_unlock = bus.wdata[slpc_pkg::BROWNOUT_UNLOCK_BIT];
  assign open_wr   = bus.wr & wr_off & wr_unlock & (win_cnt == 3'h0);
  // rewriting the unlock pattern while open neither extends nor cancels the window
  assign commit_wr = bus.wr & ~wr_unlock & (win_cnt != 3'h0);
  assign next_win_cnt = commit_wr ? 3'h0 :
                        open_wr ? slpc_pkg::UNLOCK_CYC :
                        (win_cnt != 3'h0) ? win_cnt - 3'h1 : 3'h0;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      win_cnt         <= 3'h0;
      bus.unlock_open <= 1'b0;
    end else begin
      win_cnt         <= next_win_cnt;
      bus.unlock_open <= (next_win_cnt != 3'h0);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus.sleep_off <= slpc_pkg::BROWNOUT_OFF_RESET;
    end else if (commit_wr) begin
      bus.sleep_off <= wr_off;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_off_needs_unlock: assert property (
    $changed(bus.sleep_off) |-> $past(bus.wr && !wr_unlock && win_cnt != 3'h0))
    else $error("sleep-off bit changed outside the unlock window");
  a_window_four_cyc: assert property (
    (open_wr ##1 (!bus.wr)[*4]) |=> !bus.unlock_open)
    else $error("unlock window did not close after four cycles");
  a_window_open_now: assert property (
    open_wr |=> bus.unlock_open ##1 (bus.unlock_open || $past(commit_wr)))
    else $error("unlock window not opened by the unlock write");
  c_off_set: cover property (commit_wr && wr_off);

endmodule : slpc_brownout_sleep_off_unlock

/* design/slpc_sleep_ctrl.sv */
// sleep-mode controller: clock gating, wake-up qualification and wake sequencing
`timescale 1ns/1ps
module slpc_sleep_ctrl #(
  parameter int unsigned P_BOD_WAKE_CYC =
    (slpc_pkg::BOD_WAKE_US * 1000 + slpc_pkg::CLK_PERIOD_NS - 1) / slpc_pkg::CLK_PERIOD_NS
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_sleep_instr,
  input  wire logic       i_sleep_arm,
  input  wire logic [2:0] i_sleep_mode_select,
  input  wire logic       i_ext_crystal,
  input  wire logic [1:0] i_clock_select_cfg,
  input  wire logic       i_mcu_ctrl_wr,
  input  wire logic [7:0] i_mcu_ctrl_wdata,
  input  wire logic [1:0] i_ext_irq,
  input  wire logic [1:0] i_ext_irq_en,
  input  wire logic [1:0] i_ext_irq_level,
  input  wire logic       i_pin_change,
  input  wire logic       i_ext_reset,
  input  wire logic       i_wdt_reset,
  input  wire logic       i_wdt_irq,
  input  wire logic       i_bod_reset,
  input  wire logic       i_twi_match,
  input  wire logic       i_timer2_ovf,
  input  wire logic       i_timer2_cmp,
  input  wire logic [1:0] i_timer2_irq_mask,
  input  wire logic       i_global_irq_en,
  input  wire logic       i_timer2_enabled,
  input  wire logic       i_timer2_async,
  input  wire logic       i_nvm_ready_irq,
  input  wire logic       i_adc_done_irq,
  input  wire logic       i_adc_enabled,
  input  wire logic       i_other_irq,
  output logic            o_cpu_clk_en,
  output logic            o_flash_clk_en,
  output logic            o_io_clk_en,
  output logic            o_adc_clk_en,
  output logic            o_async_clk_en,
  output logic            o_main_osc_en,
  output logic            o_timer_osc_en,
  output logic            o_timer2_sync_clk_en,
  output logic            o_bod_enable,
  output logic            o_adc_start,
  output logic            o_sleeping,
  output logic            o_cpu_halt,
  output logic            o_irq_service,
  output logic            o_reset_vector,
  output logic [7:0]      o_mcu_ctrl_rdata
);

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STARTUP, ST_HALT} slpc_state_t;

  localparam logic [15:0] BOD_WAKE_CYC = 16'(P_BOD_WAKE_CYC);

  slpc_state_t state;
  slpc_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [2:0]  mode;
  logic        bod_off_sleep;
  logic        next_bod_off_sleep;
  logic        rst_woke;
  logic        next_rst_woke;
  logic        irq_pend;
  logic        next_irq_pend;
  logic        ext_pend;
  logic        next_ext_pend;

  // pin inputs pass two flops; only the second stage is read
  logic [3:0]  sync_a;
  logic [3:0]  sync_b;
  logic [1:0]  ext_s;
  logic        pc_s;
  logic        ext_rst_s;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {i_ext_reset, i_pin_change, i_ext_irq};
      sync_b <= sync_a;
    end
  end

  assign ext_s     = sync_b[1:0];
  assign pc_s      = sync_b[2];
  assign ext_rst_s = sync_b[3];

  // brown-out sleep-off bit behind its timed unlock
  slpc_brownout_sleep_off_if brownout_sleep_off ();

  assign brownout_sleep_off.wr    = i_mcu_ctrl_wr;
  assign brownout_sleep_off.wdata = i_mcu_ctrl_wdata;

  slpc_brownout_sleep_off_unlock u_brownout_sleep_off (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .bus       (brownout_sleep_off.unit)
  );

  always_comb begin
    o_mcu_ctrl_rdata = 8'h00;
    o_mcu_ctrl_rdata[slpc_pkg::BROWNOUT_OFF_BIT]    = brownout_sleep_off.sleep_off;
    o_mcu_ctrl_rdata[slpc_pkg::BROWNOUT_UNLOCK_BIT] = brownout_sleep_off.unlock_open;
  end

  // mode decode; standby codes without a crystal fall back to power-down or power-save
  wire [2:0] eff_sel    = (i_sleep_mode_select[2:1] == 2'b11 && !i_ext_crystal) ?
                          {2'b01, i_sleep_mode_select[0]} : i_sleep_mode_select;
  wire       sel_valid  = (eff_sel != slpc_pkg::MODE_RSVD_A) && (eff_sel != slpc_pkg::MODE_RSVD_B);
  wire       sleep_go   = i_sleep_instr && i_sleep_arm && sel_valid && (state == ST_RUN);
  wire [2:0] gmode      = sleep_go ? eff_sel : mode;

  wire       g_idle     = (gmode == slpc_pkg::MODE_IDLE);
  wire       g_adcnr    = (gmode == slpc_pkg::MODE_ADC_NR);
  wire       g_stby     = (gmode == slpc_pkg::MODE_STANDBY);
  wire       g_ext_stby = (gmode == slpc_pkg::MODE_EXT_STANDBY);
  wire       g_pdown    = (gmode == slpc_pkg::MODE_PDOWN) || g_stby;
  wire       g_psave    = (gmode == slpc_pkg::MODE_PSAVE) || g_ext_stby;
  wire       g_bod_ok   = !(g_idle || g_adcnr);

  // wake qualification per mode
  wire t2_irq    = i_global_irq_en && ((i_timer2_ovf && i_timer2_irq_mask[0]) ||
                                       (i_timer2_cmp && i_timer2_irq_mask[1]));
  wire ext_any   = |(ext_s & i_ext_irq_en);
  wire ext_lvl   = |(ext_s & i_ext_irq_en & i_ext_irq_level);
  wire rst_wake  = ext_rst_s || i_wdt_reset || i_bod_reset;
  wire base_irq  = i_wdt_irq || i_twi_match || pc_s;
  wire irq_idle  = base_irq || t2_irq || i_nvm_ready_irq || i_adc_done_irq || i_other_irq;
  wire irq_adcnr = base_irq || (t2_irq && i_timer2_async) || i_nvm_ready_irq || i_adc_done_irq;
  wire irq_psave = base_irq || (t2_irq && i_timer2_enabled);
  wire irq_wake  = g_idle ? irq_idle : g_adcnr ? irq_adcnr : g_psave ? irq_psave : base_irq;
  wire ext_wake  = g_idle ? ext_any : ext_lvl;
  wire wake      = rst_wake || irq_wake || ext_wake;

  // wake-up wait: clock restart for deep modes, stretched when brown-out was off
  wire [15:0] startup_sel = (i_clock_select_cfg == 2'h0) ? slpc_pkg::STARTUP_CYC_0 :
                            (i_clock_select_cfg == 2'h1) ? slpc_pkg::STARTUP_CYC_1 :
                            (i_clock_select_cfg == 2'h2) ? slpc_pkg::STARTUP_CYC_2 :
                                                            slpc_pkg::STARTUP_CYC_3;
  wire [15:0] base_wait   = (g_stby || g_ext_stby) ? slpc_pkg::STANDBY_WAKE_CYC :
                            (g_pdown || g_psave) ? startup_sel : 16'h0000;
  wire [15:0] wake_wait   = (bod_off_sleep && BOD_WAKE_CYC > base_wait) ? BOD_WAKE_CYC : base_wait;

  always_comb begin
    next_state         = state;
    next_cnt           = cnt;
    next_rst_woke      = rst_woke;
    next_irq_pend      = irq_pend;
    next_ext_pend      = ext_pend;
    next_bod_off_sleep = bod_off_sleep;
    unique case (state)
      ST_RUN: begin
        if (sleep_go) begin
          next_state         = ST_SLEEP;
          next_bod_off_sleep = brownout_sleep_off.sleep_off && g_bod_ok;
          next_rst_woke      = 1'b0;
          next_irq_pend      = 1'b0;
          next_ext_pend      = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          next_rst_woke = rst_wake;
          next_irq_pend = irq_wake;
          next_ext_pend = ext_wake;
          if (wake_wait != 16'h0000) begin
            next_state = ST_STARTUP;
            next_cnt   = wake_wait - 16'h0001;
          end else if (rst_wake) begin
            next_state = ST_RUN;
          end else begin
            next_state = ST_HALT;
            next_cnt   = slpc_pkg::HALT_CYC - 16'h0001;
          end
        end
      end
      ST_STARTUP: begin
        next_rst_woke = rst_woke || rst_wake;
        if (cnt == 16'h0000) begin
          // a level that vanished during start-up gives no interrupt
          next_ext_pend = ext_wake;
          next_state    = next_rst_woke ? ST_RUN : ST_HALT;
          next_cnt      = slpc_pkg::HALT_CYC - 16'h0001;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      ST_HALT: begin
        if (cnt == 16'h0000) begin
          next_state = ST_RUN;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
    endcase
    if (next_state == ST_RUN) begin
      next_bod_off_sleep = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state         <= ST_RUN;
      cnt           <= 16'h0000;
      mode          <= slpc_pkg::MODE_IDLE;
      bod_off_sleep <= 1'b0;
      rst_woke      <= 1'b0;
      irq_pend      <= 1'b0;
      ext_pend      <= 1'b0;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      mode          <= gmode;
      bod_off_sleep <= next_bod_off_sleep;
      rst_woke      <= next_rst_woke;
      irq_pend      <= next_irq_pend;
      ext_pend      <= next_ext_pend;
    end
  end

  // clock-domain gating while asleep; nothing here clears state, so contents survive
  wire sl       = (next_state == ST_SLEEP);
  wire t2_sync  = i_timer2_enabled && !i_timer2_async;
  wire s_io     = g_idle;
  wire s_adc    = g_idle || g_adcnr;
  wire s_async  = g_idle || g_adcnr || (gmode == slpc_pkg::MODE_PSAVE) ||
                  (g_ext_stby && i_timer2_async);
  wire s_main   = g_idle || g_adcnr || g_stby || g_ext_stby ||
                  ((gmode == slpc_pkg::MODE_PSAVE) && t2_sync);
  wire s_tosc   = (g_idle || g_adcnr || g_psave) && i_timer2_async;
  wire s_t2sync = g_psave && t2_sync;
  wire wake_end = (state == ST_HALT) && (cnt == 16'h0000);
  wire rst_end  = (state != ST_RUN) && (next_state == ST_RUN) && next_rst_woke;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cpu_clk_en         <= 1'b1;
      o_flash_clk_en       <= 1'b1;
      o_io_clk_en          <= 1'b1;
      o_adc_clk_en         <= 1'b1;
      o_async_clk_en       <= 1'b1;
      o_main_osc_en        <= 1'b1;
      o_timer_osc_en       <= 1'b1;
      o_timer2_sync_clk_en <= 1'b1;
      o_sleeping           <= 1'b0;
      o_cpu_halt           <= 1'b0;
    end else begin
      o_cpu_clk_en         <= !sl;
      o_flash_clk_en       <= !sl;
      o_io_clk_en          <= !sl || s_io;
      o_adc_clk_en         <= !sl || s_adc;
      o_async_clk_en       <= !sl || s_async;
      o_main_osc_en        <= !sl || s_main;
      o_timer_osc_en       <= !sl || s_tosc;
      o_timer2_sync_clk_en <= !sl || s_t2sync;
      o_sleeping           <= sl;
      o_cpu_halt           <= (next_state == ST_STARTUP) || (next_state == ST_HALT);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bod_enable   <= 1'b1;
      o_adc_start    <= 1'b0;
      o_irq_service  <= 1'b0;
      o_reset_vector <= 1'b0;
    end else begin
      o_bod_enable   <= !(sl && next_bod_off_sleep);
      o_adc_start    <= sleep_go && s_adc && i_adc_enabled;
      o_irq_service  <= wake_end && (irq_pend || ext_pend);
      o_reset_vector <= rst_end;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_unarmed_no_effect: assert property (
    (i_sleep_instr && !i_sleep_arm && state == ST_RUN) |=> !o_sleeping && o_cpu_clk_en)
    else $error("unarmed sleep instruction changed the clocks");
  a_entry_needs_arm: assert property (
    $rose(o_sleeping) |-> $past(i_sleep_instr && i_sleep_arm))
    else $error("sleep entered without armed sleep instruction");
  a_idle_domains: assert property (
    (o_sleeping && mode == slpc_pkg::MODE_IDLE) |->
      o_io_clk_en && o_adc_clk_en && o_main_osc_en && !o_cpu_clk_en && !o_flash_clk_en)
    else $error("idle clock domains wrong");
  a_adcnr_domains: assert property (
    (o_sleeping && mode == slpc_pkg::MODE_ADC_NR) |-> o_adc_clk_en && !o_io_clk_en && !o_cpu_clk_en)
    else $error("adc noise reduction clock domains wrong");
  a_pdown_all_off: assert property (
    (o_sleeping && mode == slpc_pkg::MODE_PDOWN) |->
      !o_main_osc_en && !o_io_clk_en && !o_adc_clk_en && !o_async_clk_en)
    else $error("power-down left a clock running");
  a_adc_autostart: assert property (
    (sleep_go && (g_idle || g_adcnr) && i_adc_enabled) |=> o_adc_start && o_sleeping)
    else $error("adc conversion not started on sleep entry");
  a_halt_four_cyc: assert property (
    (state != ST_HALT && next_state == ST_HALT) |=> (state == ST_HALT)[*4] ##1 (state == ST_RUN))
    else $error("halt after wake not four cycles");
  a_standby_six_cyc: assert property (
    ($rose(state == ST_STARTUP) && (mode == slpc_pkg::MODE_STANDBY) && !bod_off_sleep) |->
      (state == ST_STARTUP)[*6] ##1 (state == ST_HALT || state == ST_RUN))
    else $error("standby wake not six cycles");
  a_bod_kept_shallow: assert property (
    (o_sleeping && (mode == slpc_pkg::MODE_IDLE || mode == slpc_pkg::MODE_ADC_NR)) |-> o_bod_enable)
    else $error("brown-out detector off in a shallow mode");
  a_bod_back_on: assert property (
    $fell(o_sleeping) |-> o_bod_enable)
    else $error("brown-out detector not re-enabled at wake");
  a_reset_no_irq: assert property (
    o_reset_vector |-> !o_irq_service && !o_cpu_halt && o_cpu_clk_en)
    else $error("reset wake mixed with interrupt service");

  c_idle_wake: cover property ((state == ST_SLEEP && mode == slpc_pkg::MODE_IDLE) ##1 state == ST_HALT);
  c_pdown_wake: cover property ((state == ST_SLEEP && mode == slpc_pkg::MODE_PDOWN) ##1 state == ST_STARTUP);
  c_reset_wake: cover property (o_reset_vector);
  c_bod_off: cover property (o_sleeping && !o_bod_enable);

endmodule : slpc_sleep_ctrl

/* tb/slpc_wake_src_model.sv */
// wake source model: each raised level is held until the wake is served
`timescale 1ns/1ps
module slpc_wake_src_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_raise,
  input  wire logic       i_served,
  output logic      [7:0] o_src
);
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_src <= 8'h00;
    end else if (i_served) begin
      o_src <= 8'h00;
    end else begin
      o_src <= o_src | i_raise;
    end
  end
endmodule : slpc_wake_src_model

/* tb/sleep_mode_controller_tb_top.sv */
// self-checking bench of the sleep-mode controller
`timescale 1ns/1ps
module sleep_mode_controller_tb_top;
  localparam int BODW = 20;
  logic clk = 1'b0, rstn = 1'b0, instr = 1'b0, arm = 1'b0, xtal = 1'b0, wr = 1'b0;
  logic t2en = 1'b1, t2as = 1'b1, adcen = 1'b1, gie = 1'b1;
  logic [2:0] mode = 3'h0;
  logic [1:0] cs = 2'h0, xlvl = 2'h0, t2m = 2'h1;
  logic [7:0] wdata = 8'h00, raise = 8'h00, src, rdata;
  logic cpu, fl, io, adc, asy, osc, tosc, t2c, brownout_detector, ast, slp, halt, srv, rv;
  int failures = 0, compares = 0;
  initial forever #4 clk = ~clk;
  slpc_sleep_ctrl #(.P_BOD_WAKE_CYC(BODW)) slpc_sleep_ctrl_i (
    .i_ref_clk(clk), .i_resetn(rstn), .i_sleep_instr(instr), .i_sleep_arm(arm),
    .i_sleep_mode_select(mode), .i_ext_crystal(xtal), .i_clock_select_cfg(cs), .i_mcu_ctrl_wr(wr),
    .i_mcu_ctrl_wdata(wdata), .i_ext_irq({1'b0, src[3]}), .i_ext_irq_en(2'h1), .i_ext_irq_level(xlvl),
    .i_pin_change(src[7]), .i_ext_reset(src[4]), .i_wdt_reset(1'b0), .i_wdt_irq(src[2]), .i_bod_reset(1'b0),
    .i_twi_match(src[6]), .i_timer2_ovf(src[5]), .i_timer2_cmp(src[5]), .i_timer2_irq_mask(t2m),
    .i_global_irq_en(gie), .i_timer2_enabled(t2en), .i_timer2_async(t2as), .i_nvm_ready_irq(src[1]),
    .i_adc_done_irq(src[1]), .i_adc_enabled(adcen), .i_other_irq(src[0]), .o_cpu_clk_en(cpu),
    .o_flash_clk_en(fl), .o_io_clk_en(io), .o_adc_clk_en(adc), .o_async_clk_en(asy), .o_main_osc_en(osc),
    .o_timer_osc_en(tosc), .o_timer2_sync_clk_en(t2c), .o_bod_enable(brownout_detector), .o_adc_start(ast),
    .o_sleeping(slp), .o_cpu_halt(halt), .o_irq_service(srv), .o_reset_vector(rv), .o_mcu_ctrl_rdata(rdata));
  slpc_wake_src_model slpc_wake_src_model_i (.i_ref_clk(clk), .i_resetn(rstn), .i_raise(raise),
    .i_served(srv | rv), .o_src(src));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk_bit
  task automatic chk_cnt(input int got, input int exp);
    compares++;
    if (got != exp) begin
      failures++;
      $display("unexpected at %0t: count %0d not %0d", $time, got, exp);
    end
  endtask : chk_cnt
  // expected start-up wait, from mode, start-up setting and brown-out shutdown
  function automatic int exp_wait(input logic [2:0] m, input logic boff);
    int w;
    if (m < 3'h2) return 0;
    w = (xtal && m[2]) ? 6 : (16 << (cs == 2'h0 ? 0 : cs == 2'h1 ? 4 : cs == 2'h2 ? 7 : 8));
    if (boff && w < BODW) w = BODW;
    return w;
  endfunction : exp_wait
  task automatic enter(input logic [2:0] m, input logic boff);
    mode = m;
    arm = 1'b1;
    instr = 1'b1;
    tick();
    instr = 1'b0;
    chk_bit(slp, 1'b1, "sleep entry");
    chk_bit(cpu | fl, 1'b0, "cpu clock");
    chk_bit(io, m == 3'h0, "io clock");
    chk_bit(adc, m < 3'h2, "adc clock");
    chk_bit(osc, m < 3'h2 || (xtal && m[2]) || (m[1:0] == 2'h3 && t2en && !t2as), "main osc");
    chk_bit(tosc, (m < 3'h2 || m[1:0] == 2'h3) && t2as, "timer osc");
    chk_bit(asy, m < 3'h2 || m == 3'h3 || (m == 3'h7 && (t2as || !xtal)), "async clock");
    chk_bit(t2c, m[1:0] == 2'h3 && t2en && !t2as, "timer2 sync clock");
    chk_bit(ast, m < 3'h2 && adcen, "adc start");
    chk_bit(brownout_detector, !(boff && m >= 3'h2), "bod off");
  endtask : enter
  task automatic wake(input int b, input int w);
    int n;
    n = 0;
    raise = 8'h01 << b;
    tick();
    raise = 8'h00;
    while (halt !== 1'b1 && n < 5000) begin
      tick();
      n++;
    end
    n = 0;
    while (halt === 1'b1 && n < 9000) begin
      tick();
      n++;
    end
    chk_cnt(n, w + 4);
    chk_bit(srv, 1'b1, "service");
    chk_bit(brownout_detector & ~slp, 1'b1, "awake");
    repeat (4) tick();
  endtask : wake
  task automatic idle_check(input int b);
    raise = 8'h01 << b;
    tick();
    raise = 8'h00;
    repeat (12) tick();
  endtask : idle_check
  task automatic wr_mcu(input logic [7:0] d);
    wr = 1'b1;
    wdata = d;
    tick();
    wr = 1'b0;
    tick();
  endtask : wr_mcu
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    #800000;
    failures++;
    results();
  end
  initial begin
    void'($urandom(49));
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    chk_bit(cpu & io & osc & brownout_detector & ~rdata[6], 1'b1, "reset state");
    instr = 1'b1;
    tick();
    instr = 1'b0;
    chk_bit(slp | ~cpu, 1'b0, "unarmed sleep");
    enter(3'h0, 1'b0);
    wake(0, 0);
    enter(3'h1, 1'b0);
    idle_check(0);
    chk_bit(slp, 1'b1, "adc-nr ignores irq");
    wake(1, 0);
    cs = 2'($urandom % 4);
    enter(3'h2, 1'b0);
    idle_check(3);
    chk_bit(slp, 1'b1, "edge irq ignored");
    wake(2, exp_wait(3'h2, 1'b0));
    xlvl = 2'h1;
    enter(3'h2, 1'b0);
    wake(3, exp_wait(3'h2, 1'b0));
    t2m = 2'h0;
    enter(3'h3, 1'b0);
    idle_check(5);
    chk_bit(slp, 1'b1, "timer2 masked");
    t2m = 2'h1;
    wake(5, exp_wait(3'h3, 1'b0));
    t2as = 1'b0;
    enter(3'h3, 1'b0);
    wake(5, exp_wait(3'h3, 1'b0));
    t2as = 1'b1;
    wr_mcu(8'h40);
    chk_bit(rdata[6], 1'b0, "locked write");
    wr_mcu(8'h60);
    chk_bit(rdata[5], 1'b1, "unlock window open");
    wr_mcu(8'h40);
    chk_bit(rdata[6], 1'b1, "unlocked write");
    chk_bit(rdata[5], 1'b0, "window closed by commit");
    enter(3'h0, 1'b1);
    wake(0, 0);
    cs = 2'h0;
    enter(3'h2, 1'b1);
    wake(2, exp_wait(3'h2, 1'b1));
    wr_mcu(8'h60);
    wr_mcu(8'h00);
    wr_mcu(8'h60);
    repeat (3) tick();
    wr_mcu(8'h40);
    chk_bit(rdata[6], 1'b0, "late write ignored");
    xtal = 1'b1;
    enter(3'h6, 1'b0);
    wake(2, 6);
    enter(3'h7, 1'b0);
    wake(5, 6);
    enter(3'h2, 1'b0);
    raise = 8'h10;
    tick();
    raise = 8'h00;
    repeat (60) if (rv !== 1'b1 && srv !== 1'b1) tick();
    chk_bit(rv & ~srv, 1'b1, "reset wake");
    repeat (4) tick();
    results();
  end
endmodule : sleep_mode_controller_tb_top
